// ### design/ico_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Mode 00 off, 01 cursor, 10 ink
// [R2] Software zeroes positions when ink selected
// [R3] Start code zero: top minus 1024 bytes
// [R4] Nonzero code n: top minus n times 8192
// [R5] Start address applies at next TV blank
// [R6] Software: code zero suits cursor use
// [R7] Software: ink image avoids dual-panel buffer
// [R8] Upper bit 7 is sign; negative capped 63
// [R9] Ten-bit column split over low/high bytes
// [R10] Horizontal position used only in cursor mode
// [R11] Threshold zero selects hardware automatic value
// [R12] Panel colour one held as 5/6/5
// [R13] Position waits for Y-high write, then blank
// [R14] Unused bits ignore writes, read zero
module ico_regs #(
    parameter int MEM_AW = 21,             // Display memory address width
    parameter logic [3:0] AUTO_THR = 4'h8  // Threshold used when field is 0
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [ico_pkg::ICO_BUS_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [ico_pkg::ICO_BUS_DW-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [ico_pkg::ICO_BUS_DW-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic TV_VNDP,
    input wire logic TV_Y_HIGH_WR,
    output ico_pkg::ico_panel_out_t PANEL_OUT,
    output ico_pkg::ico_tv_out_t TV_OUT,
    output logic [MEM_AW-1:0] TV_OVL_ADDR,
    output logic TV_START_PENDING,
    output logic TV_X_PENDING
);
    import ico_pkg::*;

    // ************************************************************
    // Display memory geometry
    // ************************************************************
    // One bit wider than the address so the size itself fits
    localparam logic [MEM_AW:0] MEM_SIZE = (MEM_AW + 1)'(1) << MEM_AW;
    localparam logic [MEM_AW:0] ZERO_GAP = (MEM_AW + 1)'(ICO_START_ZERO_BYTES);
    localparam int PAGE_SHIFT = $clog2(ICO_START_PAGE_BYTES);

    // ************************************************************
    // Module state
    // ************************************************************
    typedef struct packed {
        logic ack;                  // Bus answer cycle in progress
        logic [7:0] rdata;          // Captured read byte
        logic [4:0] blue1;          // Panel colour 1, blue
        logic [5:0] green1;         // Panel colour 1, green
        logic [4:0] red1;           // Panel colour 1, red
        logic [3:0] fifo_thr;       // Panel FIFO high threshold
        logic [1:0] mode;           // TV overlay function select
        logic [7:0] start_sw;       // TV start code as last written
        logic [7:0] x_low;          // TV column bits 7-0 as written
        logic x_sign;               // TV column sign as written
        logic [1:0] x_msb;          // TV column bits 9-8 as written
        logic vndp_prev;            // Blank level one cycle ago
        ico_panel_out_t panel;      // Registered panel outputs
        ico_tv_out_t tv;            // Registered TV outputs
        logic [MEM_AW-1:0] ovl_addr; // Registered overlay image base
    } ico_state_t;

    ico_state_t st_q;   // Registered state
    ico_state_t st_d;   // Next state
    ico_state_t st_rst; // Reset image of the state

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic bus_req;        // Read or write requested
    logic bus_aligned;    // Word aligned byte address
    logic [7:0] bus_idx;  // Register index from the address
    logic bus_commit;     // Cycle in which waitrequest is low
    logic wr_en;          // Write takes effect this edge
    logic [7:0] wr_byte;  // Byte lane 0 of the write data
    logic start_arm;      // Write to the start register
    logic apply;          // Onset of a TV vertical blank
    logic [7:0] start_act; // Start code now in force
    logic [10:0] x_act;   // Sign and column now in force
    logic [10:0] x_live;  // Sign and column as written

    // Requests and the one-wait-state answer
    always_comb begin
        bus_req = AVS_READ | AVS_WRITE;
        bus_aligned = (AVS_ADDRESS[1:0] == 2'b00);
        bus_idx = AVS_ADDRESS[ICO_BUS_AW-1:2];
        bus_commit = bus_req & st_q.ack;
        // Only lane 0 carries register data; other lanes are ignored
        wr_en = bus_commit & AVS_WRITE & AVS_BYTEENABLE[0] & bus_aligned;
        wr_byte = AVS_WRITEDATA[7:0];
    end

    // First request cycle always waits, so read data are registered
    assign AVS_WAITREQUEST = bus_req & ~st_q.ack;
    assign AVS_READDATA = {{(ICO_BUS_DW - ICO_REG_W){1'b0}}, st_q.rdata};

    // [R5] start arms on write
    assign start_arm = wr_en & (bus_idx == ICO_IDX_TV_START);

    // A blank is taken at its onset, so a write made inside one
    // waits for the following blank rather than landing mid-period
    assign apply = TV_VNDP & ~st_q.vndp_prev;

    assign x_live = {st_q.x_sign, st_q.x_msb, st_q.x_low};

    // ************************************************************
    // Deferred values
    // ************************************************************
    // [R5] start at next blank
    ico_shadow #(
        .W(8),
        .RST_VAL(ICO_RST_START)
    ) u_start (
        .clk(MCLK),
        .rst(RST),
        .din(st_q.start_sw),
        .arm(start_arm),
        .apply(apply),
        .q(start_act),
        .pending(TV_START_PENDING)
    );

    // [R13] position waits for Y-high
    ico_shadow #(
        .W(11),
        .RST_VAL({ICO_RST_X_HIGH, ICO_RST_X_LOW})
    ) u_xpos (
        .clk(MCLK),
        .rst(RST),
        .din(x_live),
        .arm(TV_Y_HIGH_WR),
        .apply(apply),
        .q(x_act),
        .pending(TV_X_PENDING)
    );

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    // [R14] unused bits read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] idx, input ico_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            ICO_IDX_PNL_BLUE1: begin
                v = {3'h0, s.blue1};
            end
            ICO_IDX_PNL_GREEN1: begin
                v = {2'h0, s.green1};
            end
            ICO_IDX_PNL_RED1: begin
                v = {3'h0, s.red1};
            end
            ICO_IDX_PNL_FIFO_THR: begin
                v = {4'h0, s.fifo_thr};
            end
            ICO_IDX_TV_CTRL: begin
                v = {6'h00, s.mode};
            end
            ICO_IDX_TV_START: begin
                v = s.start_sw;
            end
            ICO_IDX_TV_X_LOW: begin
                v = s.x_low;
            end
            ICO_IDX_TV_X_HIGH: begin
                v = {s.x_sign, 5'h00, s.x_msb};
            end
            // Unmapped index reads zero
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ************************************************************
    // Overlay image base
    // ************************************************************
    // Start address decode from the code in force
    function automatic logic [MEM_AW-1:0] base_of(input logic [7:0] code);
        logic [MEM_AW:0] b;
        b = MEM_SIZE - ZERO_GAP;
        if (code == 8'h00) begin
            // [R3] code zero gap
            b = MEM_SIZE - ZERO_GAP;
        end else begin
            // [R4] pages below top
            b = MEM_SIZE - ((MEM_AW + 1)'(code) << PAGE_SHIFT);
        end
        return b[MEM_AW-1:0];
    endfunction

    // ************************************************************
    // Reset image
    // ************************************************************
    always_comb begin
        st_rst = '0;
        st_rst.blue1 = ICO_RST_BLUE1;
        st_rst.green1 = ICO_RST_GREEN1;
        st_rst.red1 = ICO_RST_RED1;
        st_rst.fifo_thr = ICO_RST_FIFO_THR;
        st_rst.mode = ICO_RST_MODE;
        st_rst.start_sw = ICO_RST_START;
        st_rst.x_low = ICO_RST_X_LOW;
        {st_rst.x_sign, st_rst.x_msb} = ICO_RST_X_HIGH;
        st_rst.panel.fifo_thr = AUTO_THR;
        st_rst.panel.thr_auto = 1'b1;
        st_rst.tv.mode = ICO_MODE_OFF;
        st_rst.ovl_addr = base_of(ICO_RST_START);
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.vndp_prev = TV_VNDP;

        // Bus answer: one wait cycle, then release
        st_d.ack = bus_req & ~st_q.ack;

        // Read byte is captured while the master still waits
        if (bus_req && !st_q.ack && AVS_READ) begin
            if (bus_aligned) begin
                st_d.rdata = rd_mux(bus_idx, st_q);
            end else begin
                st_d.rdata = 8'h00;
            end
        end

        // Register writes; masks drop the unused bit positions
        if (wr_en) begin
            case (bus_idx)
                // [R12] colour 5/6/5 fields
                ICO_IDX_PNL_BLUE1: begin
                    st_d.blue1 = wr_byte[4:0];
                end
                ICO_IDX_PNL_GREEN1: begin
                    st_d.green1 = wr_byte[5:0];
                end
                ICO_IDX_PNL_RED1: begin
                    st_d.red1 = wr_byte[4:0];
                end
                ICO_IDX_PNL_FIFO_THR: begin
                    st_d.fifo_thr = wr_byte[3:0];
                end
                ICO_IDX_TV_CTRL: begin
                    st_d.mode = wr_byte[1:0];
                end
                ICO_IDX_TV_START: begin
                    st_d.start_sw = wr_byte;
                end
                // [R9] column split storage
                ICO_IDX_TV_X_LOW: begin
                    st_d.x_low = wr_byte;
                end
                ICO_IDX_TV_X_HIGH: begin
                    st_d.x_sign = wr_byte[ICO_XHI_SIGN_BIT];
                    st_d.x_msb = wr_byte[ICO_XHI_MSB_TOP:0];
                end
                // Unmapped index: write is answered and dropped
                default: begin
                    st_d.mode = st_q.mode;
                end
            endcase
        end

        // Panel outputs follow the registers directly
        st_d.panel.blue1 = st_q.blue1;
        st_d.panel.green1 = st_q.green1;
        st_d.panel.red1 = st_q.red1;
        // [R11] zero means automatic
        if (st_q.fifo_thr == 4'h0) begin
            st_d.panel.fifo_thr = AUTO_THR;
            st_d.panel.thr_auto = 1'b1;
        end else begin
            st_d.panel.fifo_thr = st_q.fifo_thr;
            st_d.panel.thr_auto = 1'b0;
        end

        // [R1] mode select decode
        case (st_q.mode)
            ICO_MODE_CURSOR: begin
                st_d.tv.mode = ICO_MODE_CURSOR;
                st_d.tv.cursor_en = 1'b1;
                st_d.tv.ink_en = 1'b0;
            end
            ICO_MODE_INK: begin
                st_d.tv.mode = ICO_MODE_INK;
                st_d.tv.cursor_en = 1'b0;
                st_d.tv.ink_en = 1'b1;
            end
            // Reserved code is held off rather than guessed at
            default: begin
                st_d.tv.mode = ICO_MODE_OFF;
                st_d.tv.cursor_en = 1'b0;
                st_d.tv.ink_en = 1'b0;
            end
        endcase

        // Image base from the start code in force
        st_d.tv.start_code = start_act;
        st_d.ovl_addr = base_of(start_act);

        // [R10] position in cursor only
        if (st_q.mode == ICO_MODE_CURSOR) begin
            st_d.tv.x_neg = x_act[10];
            // [R8] negative magnitude capped
            if (x_act[10] && (x_act[9:0] > ICO_NEG_MAX)) begin
                st_d.tv.x_mag = ICO_NEG_MAX;
            end else begin
                st_d.tv.x_mag = x_act[9:0];
            end
        end else begin
            st_d.tv.x_neg = 1'b0;
            st_d.tv.x_mag = 10'h000;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_q <= st_rst;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flops
    assign PANEL_OUT = st_q.panel;
    assign TV_OUT = st_q.tv;
    assign TV_OVL_ADDR = st_q.ovl_addr;

endmodule

// ### design/ico_shadow.sv
`timescale 1ns/1ps
// ****************************************************************
// Pending/active pair: armed by an event, loaded at the next apply
// ****************************************************************
module ico_shadow #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    input wire logic arm,
    input wire logic apply,
    output logic [W-1:0] q,
    output logic pending
);
    import ico_pkg::*;

    // Whole state of this module
    typedef struct packed {
        logic pend;
        logic [W-1:0] val;
    } ico_shd_t;

    ico_shd_t s_q;  // Registered state
    ico_shd_t s_d;  // Next state

    // An apply while pending copies the live value; an arm in the same cycle stays
    // pending, so a late write is never swallowed by this period
    always_comb begin
        s_d = s_q;
        if (apply && s_q.pend) begin
            s_d.val = din;
            s_d.pend = 1'b0;
        end
        if (arm) begin
            s_d.pend = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= {1'b0, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.val;
    assign pending = s_q.pend;

endmodule

// ### dv/ico_regs_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Overlay register bank: port-level property checker
// ****************************************************************
module ico_regs_sva #(
    parameter int MEM_AW = 21,
    parameter logic [3:0] AUTO_THR = 4'h8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [ico_pkg::ICO_BUS_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [ico_pkg::ICO_BUS_DW-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [ico_pkg::ICO_BUS_DW-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic TV_VNDP,
    input wire logic TV_Y_HIGH_WR,
    input wire ico_pkg::ico_panel_out_t PANEL_OUT,
    input wire ico_pkg::ico_tv_out_t TV_OUT,
    input wire logic [MEM_AW-1:0] TV_OVL_ADDR,
    input wire logic TV_START_PENDING,
    input wire logic TV_X_PENDING
);
    import ico_pkg::*;
    logic wr_ok; // Write committed this edge
    logic [7:0] idx; // Register index on the bus
    logic [MEM_AW-1:0] base_exp; // Base expected from active code
    assign idx = AVS_ADDRESS[9:2];
    assign wr_ok = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0] & (AVS_ADDRESS[1:0] == 2'b00);
    // Modulo arithmetic: memory size wraps to zero in MEM_AW bits
    assign base_exp = (TV_OUT.start_code == 8'h00) ? MEM_AW'(0) - MEM_AW'(ICO_START_ZERO_BYTES)
        : MEM_AW'(0) - MEM_AW'(TV_OUT.start_code) * MEM_AW'(ICO_START_PAGE_BYTES);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    a_mode_decode: assert property (wr_ok && idx == ICO_IDX_TV_CTRL |-> ##2
        TV_OUT.cursor_en == ($past(AVS_WRITEDATA[1:0], 2) == 2'b01) &&
        TV_OUT.ink_en == ($past(AVS_WRITEDATA[1:0], 2) == 2'b10)) else $error("mode enables wrong");
    a_base_addr: assert property (TV_OVL_ADDR == base_exp)
        else $error("overlay base wrong");
    a_start_defer: assert property ($changed(TV_OUT.start_code) |->
        $past(TV_VNDP, 2) && !$past(TV_VNDP, 3)) else $error("start code moved off blank");
    a_start_load: assert property ($rose(TV_VNDP) && TV_START_PENDING &&
        !(wr_ok && idx == ICO_IDX_TV_START) |=> !TV_START_PENDING) else $error("start not applied");
    a_x_arm: assert property ($rose(TV_X_PENDING) |-> $past(TV_Y_HIGH_WR))
        else $error("position armed without Y-high");
    a_x_cursor_only: assert property (!TV_OUT.cursor_en |-> TV_OUT.x_mag == 10'h000)
        else $error("position shown outside cursor");
    a_neg_limit: assert property (TV_OUT.x_neg |-> TV_OUT.x_mag <= ICO_NEG_MAX)
        else $error("negative position too large");
    a_thr_auto: assert property (wr_ok && idx == ICO_IDX_PNL_FIFO_THR |-> ##2
        PANEL_OUT.thr_auto == ($past(AVS_WRITEDATA[3:0], 2) == 4'h0) && PANEL_OUT.fifo_thr ==
        (PANEL_OUT.thr_auto ? AUTO_THR : $past(AVS_WRITEDATA[3:0], 2))) else $error("threshold wrong");
    a_blue_write: assert property (wr_ok && idx == ICO_IDX_PNL_BLUE1 |-> ##2
        PANEL_OUT.blue1 == $past(AVS_WRITEDATA[4:0], 2)) else $error("blue colour wrong");
    a_read_upper: assert property (AVS_READ && !AVS_WAITREQUEST |->
        AVS_READDATA[31:8] == '0) else $error("read upper bits set");
    c_blank_load: cover property ($rose(TV_VNDP) && TV_START_PENDING);
    c_neg_x: cover property (TV_OUT.x_neg && TV_OUT.cursor_en);
    c_ink: cover property (TV_OUT.ink_en);
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
bind ico_regs ico_regs_sva #(.MEM_AW(MEM_AW), .AUTO_THR(AUTO_THR)) i_ico_regs_sva (
    .MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TV_VNDP(TV_VNDP),
    .TV_Y_HIGH_WR(TV_Y_HIGH_WR), .PANEL_OUT(PANEL_OUT), .TV_OUT(TV_OUT),
    .TV_OVL_ADDR(TV_OVL_ADDR), .TV_START_PENDING(TV_START_PENDING), .TV_X_PENDING(TV_X_PENDING));
module testbench;
    import ico_pkg::*;
    localparam int AW = 21; // Memory of 2 MiB
    localparam logic [3:0] ATHR = 4'h8;
    localparam logic [7:0] IDX [8] = '{ICO_IDX_PNL_BLUE1, ICO_IDX_PNL_GREEN1, ICO_IDX_PNL_RED1,
        ICO_IDX_PNL_FIFO_THR, ICO_IDX_TV_CTRL, ICO_IDX_TV_START, ICO_IDX_TV_X_LOW, ICO_IDX_TV_X_HIGH};
    localparam logic [7:0] MSK [8] = '{8'h1f, 8'h3f, 8'h1f, 8'h0f, 8'h03, 8'hff, 8'hff, 8'h83};
    localparam logic [7:0] CODES [3] = '{8'h01, 8'hff, 8'h00};
    logic mclk, rst, rd_s, wr_s, wait_r, vndp, y_wr, spend, xpend;
    logic [ICO_BUS_AW-1:0] addr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] ben;
    logic [AW-1:0] base;
    ico_panel_out_t pnl;
    ico_tv_out_t tv;
    int err_total, comparisons, prev, exp_b;
    ico_regs #(.MEM_AW(AW), .AUTO_THR(ATHR)) i_ico_regs (.MCLK(mclk), .RST(rst),
        .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(ben), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r), .TV_VNDP(vndp),
        .TV_Y_HIGH_WR(y_wr), .PANEL_OUT(pnl), .TV_OUT(tv), .TV_OVL_ADDR(base),
        .TV_START_PENDING(spend), .TV_X_PENDING(xpend));
    // ************************************************************
    // Clock and closing report
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ************************************************************
    // Bus cycle: hold request until waitrequest is seen low
    // ************************************************************
    task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d, input logic be);
        int n;
        addr <= {i, 2'b00};
        wdata <= {24'h0000_00, d};
        ben <= {3'b000, be};
        wr_s <= w;
        rd_s <= !w;
        // Waitrequest is taken at the rising edge itself, before that
        // edge's register updates land, so it is the value the slave saw
        for (n = 0; n < 16; n++) begin
            @(posedge mclk);
            if (wait_r === 1'b0) break;
        end
        if (n == 16) begin
            err_total++;
            $display("CHECK FAILED waitrequest expected 0 seen 1");
            end_sim();
        end
        // Read data stand at the same edge; release only after it
        rdat = rdata;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        // Idle edge between requests, and one more for the output flops
        repeat (2) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, i, d, 1'b1);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] i, input logic [7:0] exp);
        acc(1'b0, i, 8'h00, 1'b1);
        chk(nm, {24'h0000_00, exp}, rdat);
    endtask
    // Blank interval long enough for the two-flop apply path
    task automatic blank();
        vndp <= 1'b1;
        repeat (2) @(posedge mclk);
        vndp <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic ypulse();
        y_wr <= 1'b1;
        @(posedge mclk);
        y_wr <= 1'b0;
        @(posedge mclk);
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rst, rd_s, wr_s, vndp, y_wr, addr, wdata, ben} = '0;
        rst = 1'b1;
        {err_total, comparisons} = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int k = 0; k < 8; k++) rdchk("reset value", IDX[k], 8'h00);
        chk("reset threshold", {ATHR, 1'b1}, {pnl.fifo_thr, pnl.thr_auto});
        chk("reset base", (1 << AW) - 1024, base);
        $display("Test reset done");
        for (int k = 0; k < 8; k++) begin
            wr(IDX[k], 8'hff);
            rdchk("masked readback", IDX[k], MSK[k]);
        end
        chk("panel colour", 16'hffff, {pnl.blue1, pnl.green1, pnl.red1});
        chk("manual threshold", 5'h1e, {pnl.fifo_thr, pnl.thr_auto});
        wr(ICO_IDX_PNL_FIFO_THR, 8'h00);
        chk("auto threshold", {ATHR, 1'b1}, {pnl.fifo_thr, pnl.thr_auto});
        acc(1'b1, ICO_IDX_PNL_BLUE1, 8'h05, 1'b0);
        rdchk("disabled lane", ICO_IDX_PNL_BLUE1, 8'h1f);
        rdchk("unmapped", 8'h7d, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(ICO_IDX_TV_CTRL, 8'(m));
            chk("mode enables", {m == 1, m == 2}, {tv.cursor_en, tv.ink_en});
            chk("mode output", (m == 3) ? 0 : m, tv.mode);
        end
        $display("Test registers done");
        blank();
        prev = 8'hff;
        // Code zero for cursor use, high codes keep clear of the top buffer
        for (int k = 0; k < 3; k++) begin
            wr(ICO_IDX_TV_START, CODES[k]);
            repeat (4) @(posedge mclk);
            chk("start pending", 1, spend);
            chk("code held", prev, tv.start_code);
            blank();
            exp_b = (CODES[k] == 8'h00) ? (1 << AW) - 1024 : (1 << AW) - CODES[k] * 8192;
            chk("code applied", CODES[k], tv.start_code);
            chk("overlay base", exp_b, base);
            chk("start released", 0, spend);
            prev = CODES[k];
        end
        $display("Test start address done");
        wr(ICO_IDX_TV_CTRL, 8'h01);
        wr(ICO_IDX_TV_X_LOW, 8'h34);
        wr(ICO_IDX_TV_X_HIGH, 8'h02);
        blank();
        chk("x without y-high", 0, tv.x_mag);
        ypulse();
        chk("x pending", 1, xpend);
        blank();
        chk("x positive", {1'b0, 10'h234}, {tv.x_neg, tv.x_mag});
        wr(ICO_IDX_TV_X_HIGH, 8'h80);
        wr(ICO_IDX_TV_X_LOW, 8'h50);
        ypulse();
        blank();
        chk("x negative", {1'b1, 10'h03f}, {tv.x_neg, tv.x_mag});
        wr(ICO_IDX_TV_CTRL, 8'h02);
        chk("x in ink", 0, tv.x_mag);
        // Ink use: positions cleared by software
        wr(ICO_IDX_TV_X_LOW, 8'h00);
        wr(ICO_IDX_TV_X_HIGH, 8'h00);
        ypulse();
        blank();
        chk("ink enable", 1, tv.ink_en);
        $display("Test position done");
        end_sim();
    end
endmodule

// ### pkg/ico_pkg.sv
// ****************************************************************
// Overlay register bank: shared constants and carriers
// ****************************************************************
package ico_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ICO_BUS_AW = 10;  // Byte address width
    localparam int ICO_BUS_DW = 32;  // Avalon data width
    localparam int ICO_REG_W = 8;    // Width of each register

    // ************************************************************
    // Register indices; byte address is four times the index
    // ************************************************************
    localparam logic [7:0] ICO_IDX_PNL_BLUE1 = 8'h7a;
    localparam logic [7:0] ICO_IDX_PNL_GREEN1 = 8'h7b;
    localparam logic [7:0] ICO_IDX_PNL_RED1 = 8'h7c;
    localparam logic [7:0] ICO_IDX_PNL_FIFO_THR = 8'h7e;
    localparam logic [7:0] ICO_IDX_TV_CTRL = 8'h80;
    localparam logic [7:0] ICO_IDX_TV_START = 8'h81;
    localparam logic [7:0] ICO_IDX_TV_X_LOW = 8'h82;
    localparam logic [7:0] ICO_IDX_TV_X_HIGH = 8'h83;

    // ************************************************************
    // Field layout of the upper horizontal byte
    // ************************************************************
    localparam int ICO_XHI_SIGN_BIT = 7;  // Sign flag, 1 = negative
    localparam int ICO_XHI_MSB_TOP = 1;   // Bits 1-0 carry bits 9-8

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [4:0] ICO_RST_BLUE1 = 5'h00;
    localparam logic [5:0] ICO_RST_GREEN1 = 6'h00;
    localparam logic [4:0] ICO_RST_RED1 = 5'h00;
    localparam logic [3:0] ICO_RST_FIFO_THR = 4'h0;
    localparam logic [1:0] ICO_RST_MODE = 2'h0;
    localparam logic [7:0] ICO_RST_START = 8'h00;
    localparam logic [7:0] ICO_RST_X_LOW = 8'h00;
    localparam logic [2:0] ICO_RST_X_HIGH = 3'h0;

    // ************************************************************
    // Start address encoding and position limits
    // ************************************************************
    localparam int ICO_START_ZERO_BYTES = 1024;  // Gap below top for code 0
    localparam int ICO_START_PAGE_BYTES = 8192;  // Step per nonzero code
    localparam logic [9:0] ICO_NEG_MAX = 10'h03f; // Largest negative magnitude

    // Overlay function select
    typedef enum logic [1:0] {
        ICO_MODE_OFF = 2'b00,
        ICO_MODE_CURSOR = 2'b01,
        ICO_MODE_INK = 2'b10,
        ICO_MODE_RSVD = 2'b11
    } ico_mode_t;

    // Flat-panel overlay settings as seen by the display pipe
    typedef struct packed {
        logic [4:0] blue1;
        logic [5:0] green1;
        logic [4:0] red1;
        logic [3:0] fifo_thr;
        logic thr_auto;
    } ico_panel_out_t;

    // CRT/TV overlay settings as seen by the display pipe
    typedef struct packed {
        ico_mode_t mode;
        logic cursor_en;
        logic ink_en;
        logic [7:0] start_code;
        logic x_neg;
        logic [9:0] x_mag;
    } ico_tv_out_t;

endpackage
